/* File: logic/sfmt_pkg.sv */
package sfmt_pkg;
  // Frame identity and shape.
  localparam logic [10:0] SFMT_COB_BASE    = 11'h4e0;
  localparam logic [3:0]  SFMT_DLC         = 4'h6;
  localparam int          SFMT_CLK_MHZ     = 100;
  localparam int          SFMT_DELAY_MS    = 12;
  localparam int          SFMT_DELAY_CYC   = SFMT_DELAY_MS * 1000 * SFMT_CLK_MHZ;
  localparam int          SFMT_CNT_W       = 21;
  // Flag word eight bit positions.
  localparam int SFMT_B_AUTODET   = 0;
  localparam int SFMT_B_IDMISS    = 1;
  localparam int SFMT_B_SERIAL    = 2;
  localparam int SFMT_B_PWRBRD    = 3;
  localparam int SFMT_B_UNSUPP    = 4;
  localparam int SFMT_B_RESALM    = 5;
  localparam int SFMT_B_RESSHD    = 6;
  localparam int SFMT_B_LINK1     = 11;
  localparam int SFMT_B_LINK2     = 12;
  localparam int SFMT_B_LINKALL   = 13;
  localparam logic [15:0] SFMT_W8_RESET = 16'h0000;
  localparam int SFMT_RES_W = 16;
  typedef enum logic [1:0] {SFMT_IDLE, SFMT_WAIT, SFMT_SEND} sfmt_state_t;
endpackage

/* File: logic/sfmt_snap_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Snapshot of the three flag words handed from assembly to packing.
interface sfmt_snap_if;
  logic [15:0] word8;
  logic [15:0] word9;
  logic [15:0] word10;
  logic [47:0] payload;
  modport src (output word8, output word9, output word10, input payload);
  modport pack (input word8, input word9, input word10, output payload);
endinterface
`default_nettype wire

/* File: logic/sfmt_packer.sv */
`timescale 1ns/1ps
`default_nettype none
module sfmt_packer
  import sfmt_pkg::*;
(
  sfmt_snap_if.pack snap
);
  // Each word goes out low byte first, word eight in the first two bytes.
  assign snap.payload = {snap.word10[15:8], snap.word10[7:0],
                         snap.word9[15:8],  snap.word9[7:0],
                         snap.word8[15:8],  snap.word8[7:0]};
endmodule
`default_nettype wire

/* File: logic/sfmt_status_tx.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - One frame 12 ms after a trigger taken in idle; triggers while waiting or sending are ignored.
// - Identifier is 0x4E0 plus node ID.
// - Data length code is six bytes.
// - Words eight, nine, ten in byte pairs.
// - Bit 0: ID module access or records fail.
// - Bit 1: ID module unreadable at power-up.
// - Bit 2: serial number mismatches valve type.
// - Bit 3: actuator incompatible with power stage.
// - Bit 4: actuator newer than firmware.
// - Bit 5: resolver difference above alarm threshold.
// - Bit 6: resolver shutdown disagreement.
// - Bit 6 only above larger shutdown threshold.
// - Bits 11,12 link errors; 13 both.
module sfmt_status_tx
  import sfmt_pkg::*;
#(
  parameter int DelayCycles = SFMT_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Trigger and node address.
  input  wire logic                  triggerRxMessage,
  input  wire logic [6:0]            nodeId,
  // Fault causes for flag word eight.
  input  wire logic                  idModuleCommFail,
  input  wire logic                  idModuleRecordsBad,
  input  wire logic                  idModulePowerUpFail,
  input  wire logic                  serialMismatch,
  input  wire logic                  powerBoardMismatch,
  input  wire logic                  actuatorUnsupported,
  input  wire logic [SFMT_RES_W-1:0] resolverDiff,
  input  wire logic [SFMT_RES_W-1:0] resolverAlarmLimit,
  input  wire logic [SFMT_RES_W-1:0] resolverShutdownLimit,
  input  wire logic                  link1Error,
  input  wire logic                  link2Error,
  // Flag words nine and ten from outside detectors.
  input  wire logic [15:0]           flagWord9,
  input  wire logic [15:0]           flagWord10,
  // Frame to the CAN controller.
  output logic                       frameValid,
  input  wire logic                  frameReady,
  output logic [10:0]                frameId,
  output logic [3:0]                 frameDlc,
  output logic [47:0]                framePayload,
  // Readable flag word eight.
  output logic [15:0]                faultFlagsWordEight
);

  ////////////////////////////////////////////////////////////////////////////
  // Flag word eight assembly.

  logic [15:0] word8Live;
  logic        resAlarm;
  logic        resShutdown;

  // Resolver comparisons against per-valve-type thresholds.
  assign resAlarm    = resolverDiff > resolverAlarmLimit;
  assign resShutdown = resolverDiff > resolverShutdownLimit;

  // Undefined positions stay zero so the far end never sees noise.
  always_comb begin
    word8Live = SFMT_W8_RESET;
    word8Live[SFMT_B_AUTODET]  = idModuleCommFail | idModuleRecordsBad;
    word8Live[SFMT_B_IDMISS]   = idModulePowerUpFail;
    word8Live[SFMT_B_SERIAL]   = serialMismatch;
    word8Live[SFMT_B_PWRBRD]   = powerBoardMismatch;
    word8Live[SFMT_B_UNSUPP]   = actuatorUnsupported;
    word8Live[SFMT_B_RESALM]   = resAlarm;
    word8Live[SFMT_B_RESSHD]   = resShutdown;
    word8Live[SFMT_B_LINK1]    = link1Error;
    word8Live[SFMT_B_LINK2]    = link2Error;
    word8Live[SFMT_B_LINKALL]  = link1Error & link2Error;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot and packing.

  sfmt_snap_if snap ();
  logic [15:0] snap8_q;
  logic [15:0] snap9_q;
  logic [15:0] snap10_q;

  assign snap.word8  = snap8_q;
  assign snap.word9  = snap9_q;
  assign snap.word10 = snap10_q;

  sfmt_packer sfmt_packer_i (
    .snap (snap.pack)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Delay and launch sequencing.

  sfmt_state_t          state_q;
  sfmt_state_t          state_d;
  logic [SFMT_CNT_W-1:0] count_q;
  logic                  delayDone;
  logic                  launch;
  logic                  accepted;

  assign delayDone = count_q == SFMT_CNT_W'(DelayCycles - 1);
  assign launch    = (state_q == SFMT_WAIT) && delayDone;
  assign accepted  = frameValid && frameReady;

  // A trigger while waiting or sending is not counted twice; the frame
  // already pending covers it, which trades strict counting for safety.
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFMT_IDLE: if (triggerRxMessage) state_d = SFMT_WAIT;
      SFMT_WAIT: if (delayDone) state_d = SFMT_SEND;
      SFMT_SEND: if (accepted) state_d = SFMT_IDLE;
      default:   state_d = SFMT_IDLE;
    endcase
  end

  // State and delay counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SFMT_IDLE;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= (state_q == SFMT_WAIT) ? count_q + 1'b1 : '0;
    end
  end

  // All three words are caught in the same edge as the launch.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap8_q  <= SFMT_W8_RESET;
      snap9_q  <= SFMT_W8_RESET;
      snap10_q <= SFMT_W8_RESET;
    end else if (launch) begin
      snap8_q  <= word8Live;
      snap9_q  <= flagWord9;
      snap10_q <= flagWord10;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frameValid          <= 1'b0;
      frameId             <= '0;
      frameDlc            <= '0;
      framePayload        <= '0;
      faultFlagsWordEight <= SFMT_W8_RESET;
    end else begin
      faultFlagsWordEight <= word8Live;
      frameValid          <= (state_q == SFMT_SEND) && !accepted;
      if (state_q == SFMT_SEND && !frameValid) begin
        framePayload <= snap.payload;
        frameId      <= SFMT_COB_BASE + {4'h0, nodeId};
        frameDlc     <= SFMT_DLC;
      end
    end
  end

  // Fields load in the first SEND cycle and valid rises in the same edge,
  // so the far end never sees valid beside a half-built frame.

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  frame_dlc_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameValid |-> frameDlc == SFMT_DLC)
    else $error("Frame length is not six bytes.");

  frame_id_a: assert property (@(posedge clk) disable iff (!rst_n)
    frameValid |-> frameId == SFMT_COB_BASE + {4'h0, nodeId})
    else $error("Frame identifier wrong.");

  link_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    faultFlagsWordEight[SFMT_B_LINKALL] ==
    (faultFlagsWordEight[SFMT_B_LINK1] & faultFlagsWordEight[SFMT_B_LINK2]))
    else $error("Both-links flag disagrees.");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    faultFlagsWordEight[10:7] == 4'h0 && faultFlagsWordEight[15:14] == 2'h0)
    else $error("Reserved bits of word eight set.");

  snap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    launch |=> snap9_q == $past(flagWord9) && snap10_q == $past(flagWord10))
    else $error("Snapshot not taken at launch.");

  trig_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == SFMT_IDLE && triggerRxMessage) |=> state_q == SFMT_WAIT)
    else $error("Trigger did not start delay.");

  byte_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(frameValid) |-> framePayload[7:0] == snap8_q[7:0]
      && framePayload[47:40] == snap10_q[15:8])
    else $error("Payload byte order wrong.");

  shd_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    faultFlagsWordEight[SFMT_B_RESSHD] |->
      $past(resolverDiff) > $past(resolverShutdownLimit))
    else $error("Shutdown flag without threshold breach.");

  frame_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frameValid && !frameReady) |=> frameValid && $stable(framePayload))
    else $error("Frame changed before acceptance.");

  launch_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
    launch |=> !frameValid ##1 frameValid)
    else $error("Frame did not follow the launch.");

endmodule
`default_nettype wire

/* File: tb/sfmt_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfmt_ctrl_model (
  // Clock.
  input  wire logic clk,
  // Frame handshake.
  input  wire logic frameValid,
  input  wire logic slow,
  output logic      frameReady
);
  logic [1:0] waitQ;

  // Counts stall cycles so a slow controller holds the frame waiting.
  always_ff @(posedge clk) begin
    waitQ <= frameValid ? waitQ + 2'h1 : 2'h0;
  end

  assign frameReady = frameValid && (!slow || waitQ == 2'h3);
endmodule
`default_nettype wire

/* File: tb/sfmt_status_tx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sfmt_status_tx_tb;
  import sfmt_pkg::*;
  localparam int Dly = 20;
  logic        clk, rst_n, trig, slow, valid, ready;
  logic        c0, c1, c2, c3, c4, c5, l1, l2;
  logic [6:0]  node;
  logic [15:0] diff, alm, shd, w9, w10, w8;
  logic [10:0] fid;
  logic [3:0]  dlc;
  logic [47:0] pay;
  logic [62:0] expQ[$];
  int          seed = 3;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          frames = 0;
  int          n;

  sfmt_status_tx #(.DelayCycles(Dly)) sfmt_status_tx_i (
    .clk(clk), .rst_n(rst_n), .triggerRxMessage(trig), .nodeId(node),
    .idModuleCommFail(c0), .idModuleRecordsBad(c1),
    .idModulePowerUpFail(c2), .serialMismatch(c3),
    .powerBoardMismatch(c4), .actuatorUnsupported(c5),
    .resolverDiff(diff), .resolverAlarmLimit(alm),
    .resolverShutdownLimit(shd), .link1Error(l1), .link2Error(l2),
    .flagWord9(w9), .flagWord10(w10), .frameValid(valid),
    .frameReady(ready), .frameId(fid), .frameDlc(dlc),
    .framePayload(pay), .faultFlagsWordEight(w8));

  sfmt_ctrl_model sfmt_ctrl_model_i (
    .clk(clk), .frameValid(valid), .slow(slow), .frameReady(ready));

  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [62:0] seen, logic [62:0] e);
    samples_checked++;
    if (seen !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, seen);
    end
  endtask

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reserved bits are left zero on purpose.
  function automatic logic [15:0] expW8();
    return {2'h0, l1 & l2, l2, l1, 4'h0, diff > shd, diff > alm,
            c5, c4, c3, c2, c0 | c1};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog: a run of twelve frames needs well under 20 us.
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end

  // Each accepted frame is matched against the oldest expectation; the
  // handshake is looked at mid-cycle, before the edge that takes it.
  always @(negedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) begin
      frames++;
      if (expQ.size() == 0) check("extraFrame", 63'h1, 63'h0);
      else check("frame", {fid, dlc, pay}, expQ.pop_front());
    end
  end

  // Random flags, resolver values around each limit, slow and fast sinks.
  initial begin
    {trig, slow, rst_n, c0, c1, c2, c3, c4, c5, l1, l2} = '0;
    {node, diff, alm, shd, w9, w10} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check("validAfterReset", 63'(valid), 63'h0);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      {c5, c4, c3, c2, c1, c0, l2, l1} = 8'($random(seed));
      node = 7'($random(seed));
      alm = {1'b0, 15'($random(seed))};
      diff = alm + 16'(i % 3) - 16'h0001;
      shd = diff - 16'(i % 2);
      w9 = 16'($random(seed));
      w10 = 16'($random(seed));
      slow = i[0];
      @(negedge clk);
      check("flagWord8", 63'(w8), 63'(expW8()));
      trig = 1'b1;
      expQ.push_back({11'h4e0 + 11'(node), 4'h6, w10, w9, expW8()});
      @(negedge clk);
      trig = (i == 2);
      @(negedge clk);
      trig = 1'b0;
      n = 2;
      while (valid !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      check("latency", 63'(n), 63'(Dly + 2));
      // Late input changes must not leak into a launched frame.
      w9 = ~w9;
      c0 = ~c0;
      while (valid === 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
    end
    repeat (Dly + 5) @(negedge clk);
    check("frameCount", 63'(frames), 63'd12);
    finish_test();
  end
endmodule
`default_nettype wire
